//--- rtl/odsfi_pkg.sv
// Package with constants and types for the octal converter serial frame input
// Contract
// - While frame select low, shift data input into 16-bit register on falling serial clock.
// - Frame select rising after 16th falling edge updates converter from captured word.
// - Frame select rising before 15th falling edge aborts; nothing changes.
// - Chain output carries data only when frame runs beyond 16 serial clocks.
// - Captured word selects mode, power-down and channel value; all, one or a masked set of channels.
// - At power-up every channel output is zero until first complete valid write.
package odsfi_pkg;
  localparam int WORD_W      = 16;
  localparam int CHAN_N      = 8;
  localparam int VAL_W       = 12;
  localparam int MIN_EDGES   = 15;
  localparam int FULL_EDGES  = 16;
  // Word layout: [15:12] command, [11:0] value or channel mask
  localparam int CMD_HI      = 15;
  localparam int CMD_LO      = 12;
  localparam logic [3:0] CMD_WRM_LO = 4'h0;  // Commands 0..7 write channel register; in write-through mode also the output
  localparam logic [3:0] CMD_WRM_HI = 4'h7;
  localparam logic [3:0] CMD_WTM_LO = 4'h8;  // 8 + write-register mode, 9 + write-through mode
  localparam logic [3:0] CMD_MODE_WRM = 4'h8;
  localparam logic [3:0] CMD_MODE_WTM = 4'h9;
  localparam logic [3:0] CMD_UPDATE   = 4'ha;  // Update selected channels from registers
  localparam logic [3:0] CMD_CHA_ALL  = 4'hb;  // Write channel A value and update all
  localparam logic [3:0] CMD_ALL      = 4'hc;  // Write all registers and outputs
  localparam logic [3:0] CMD_PD       = 4'hd;  // Power down selected channels
  localparam logic [VAL_W-1:0] VAL_RST = 12'h000;

  typedef struct packed {
    logic        frame_n;
    logic        sclk;
    logic        din;
  } odsfi_pins_t;

  typedef struct packed {
    logic [CMD_HI-CMD_LO:0] cmd;
    logic [VAL_W-1:0]       val;
  } odsfi_word_t;
endpackage

//--- rtl/odsfi_buf2.sv
// Two-entry valid/ready buffer for captured words
module odsfi_buf2 #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];
  logic         wp_reg;
  logic         rp_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (ce) begin
      if (push) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg          <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Registered read data: head entry held in a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_data <= '0;
    end else if (ce) begin
      if (pop) begin
        out_data <= (cnt_reg == 2'h2) ? mem_reg[~rp_reg] : (push ? in_data : out_data);
      end else if (push && cnt_reg == 2'h0) begin
        out_data <= in_data;
      end
    end
  end
endmodule // odsfi_buf2

//--- rtl/odsfi_top.sv
// Serial frame input of an octal converter: capture, chain output, channel update
module odsfi_top #(
  parameter int WORD_W_P = odsfi_pkg::WORD_W
) (
  input  wire logic                                         clk,
  input  wire logic                                         nrst,
  input  wire logic                                         ce,
  input  wire odsfi_pkg::odsfi_pins_t                       pins,
  output logic                                              chain_out,
  output logic [odsfi_pkg::CHAN_N-1:0][odsfi_pkg::VAL_W-1:0] chan_val,
  output logic [odsfi_pkg::CHAN_N-1:0]                      chan_pd,
  output logic                                              write_through,
  output logic                                              update_pulse,
  output logic                                              abort_pulse
);
  import odsfi_pkg::*;

  // The decoder's field layout is fixed, so no other width can be served
  if (WORD_W_P != WORD_W) begin : g_bad_width
    $error("odsfi_top: word width must be 16");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LONG  = 2'b11
  } odsfi_state_t;

  odsfi_pins_t  sync1_reg;
  odsfi_pins_t  sync2_reg;
  logic         sclk_d_reg;
  logic         frame_d_reg;
  odsfi_state_t state_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [4:0]   edges_reg;
  logic         sclk_fall;
  logic         frame_fall;
  logic         frame_rise;
  logic         cap_valid;
  logic         cap_ready;
  logic         word_valid;
  logic [WORD_W-1:0] word_data;
  odsfi_word_t  word;
  logic [CHAN_N-1:0][VAL_W-1:0] hold_reg;

  // Two flops on every pin before any logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= '{frame_n: 1'b1, sclk: 1'b1, din: 1'b0};
      sync2_reg <= '{frame_n: 1'b1, sclk: 1'b1, din: 1'b0};
    end else if (ce) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_d_reg  <= 1'b1;
      frame_d_reg <= 1'b1;
    end else if (ce) begin
      sclk_d_reg  <= sync2_reg.sclk;
      frame_d_reg <= sync2_reg.frame_n;
    end
  end

  assign sclk_fall  = sclk_d_reg && !sync2_reg.sclk;
  assign frame_fall = frame_d_reg && !sync2_reg.frame_n;
  assign frame_rise = !frame_d_reg && sync2_reg.frame_n;

  // Frame sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      edges_reg <= 5'h00;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          edges_reg <= 5'h00;
          if (frame_fall) begin
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (frame_rise) begin
            state_reg <= ST_IDLE;
          end else if (sclk_fall) begin
            edges_reg <= edges_reg + 5'h01;
            if (edges_reg == 5'(FULL_EDGES)) begin
              state_reg <= ST_LONG;  // 17th edge: frame runs past 16 clocks
            end
          end
        end
        ST_LONG: begin
          if (frame_rise) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Shift on falling serial clock while the frame is open
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_reg <= '0;
    end else if (ce && state_reg != ST_IDLE && !frame_rise && sclk_fall) begin
      shift_reg <= {shift_reg[WORD_W-2:0], sync2_reg.din};
    end
  end

  // Chain output is the bit leaving the far end, only in a long frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chain_out <= 1'b0;
    end else if (ce) begin
      chain_out <= (state_reg == ST_LONG) ? shift_reg[WORD_W-1] : 1'b0;
    end
  end

  // Accept on close after 16 edges; edges 15 also accepted, shorter frames dropped
  // An over-long frame still commits the last 16 bits, as a chained device must
  assign cap_valid = ce && frame_rise && state_reg != ST_IDLE &&
                     (state_reg == ST_LONG || edges_reg >= 5'(MIN_EDGES));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      abort_pulse <= 1'b0;
    end else if (ce) begin
      abort_pulse <= frame_rise && state_reg == ST_SHIFT && edges_reg < 5'(MIN_EDGES);
    end
  end

  // Buffer decouples capture from the decoder; decoder always drains in one cycle
  odsfi_buf2 #(.W(WORD_W)) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (shift_reg),
    .out_valid (word_valid),
    .out_ready (1'b1),
    .out_data  (word_data)
  );

  assign word = odsfi_word_t'(word_data);

  // Word decoder; outputs zero until the first valid write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_reg      <= '0;
      chan_val      <= '0;
      chan_pd       <= '0;
      write_through <= 1'b0;
      update_pulse  <= 1'b0;
    end else if (ce) begin
      update_pulse <= word_valid;
      if (word_valid) begin
        case (word.cmd)
          CMD_MODE_WRM: write_through <= 1'b0;
          CMD_MODE_WTM: write_through <= 1'b1;
          CMD_UPDATE: begin
            for (int i = 0; i < CHAN_N; i++) begin
              if (word.val[i]) begin
                chan_val[i] <= hold_reg[i];
                chan_pd[i]  <= 1'b0;
              end
            end
          end
          CMD_CHA_ALL: begin
            for (int i = 0; i < CHAN_N; i++) begin
              chan_val[i] <= (i == 0) ? word.val : hold_reg[i];
              chan_pd[i]  <= 1'b0;
            end
            hold_reg[0] <= word.val;
          end
          CMD_ALL: begin
            for (int i = 0; i < CHAN_N; i++) begin
              hold_reg[i] <= word.val;
              chan_val[i] <= word.val;
              chan_pd[i]  <= 1'b0;
            end
          end
          CMD_PD: begin
            for (int i = 0; i < CHAN_N; i++) begin
              if (word.val[i]) begin
                chan_pd[i] <= 1'b1;
              end
            end
          end
          default: begin
            if (word.cmd <= CMD_WRM_HI) begin
              hold_reg[word.cmd[2:0]] <= word.val;
              if (write_through) begin
                chan_val[word.cmd[2:0]] <= word.val;
                chan_pd[word.cmd[2:0]]  <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  logic unused_ready;
  assign unused_ready = cap_ready;
endmodule // odsfi_top

//--- tb/odsfi_host.sv
// Host serial master model driving the frame pins
module odsfi_host (
  input  wire logic             clk,
  output odsfi_pkg::odsfi_pins_t pins
);
  timeunit 1ns / 1ps;
  import odsfi_pkg::*;
  initial pins = 3'b110;
  // Serial clock idles high and stands still between frames
  task automatic send(input logic [31:0] b, input int n);
    pins.frame_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      pins.din <= b[i];
      repeat (4) @(posedge clk);
      pins.sclk <= 1'b0;
      repeat (4) @(posedge clk);
      pins.sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    pins.frame_n <= 1'b1;
    pins.din <= ~pins.din;
    repeat (12) @(posedge clk);
  endtask
endmodule  // odsfi_host

//--- tb/odsfi_props.sv
// Concurrent checks on the serial frame input ports
module odsfi_props import odsfi_pkg::*; (
  input wire logic                         clk,
  input wire logic                         nrst,
  input wire odsfi_pins_t                  pins,
  input wire logic                         chain_out,
  input wire logic [CHAN_N-1:0][VAL_W-1:0] chan_val,
  input wire logic [CHAN_N-1:0]            chan_pd,
  input wire logic                         write_through,
  input wire logic                         update_pulse,
  input wire logic                         abort_pulse
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_pulse_excl: assert property (!(update_pulse && abort_pulse))
    else $error("update with abort");
  a_update_late: assert property (update_pulse |-> $past(pins.frame_n, 3) && !$past(pins.frame_n, 10))
    else $error("update off frame end");
  a_abort_late: assert property (abort_pulse |-> $past(pins.frame_n, 3) && !$past(pins.frame_n, 10))
    else $error("abort off frame end");
  a_update_one: assert property (update_pulse |=> !update_pulse)
    else $error("update too long");
  a_abort_one: assert property (abort_pulse |=> !abort_pulse)
    else $error("abort too long");
  a_vals_hold: assert property (!update_pulse |-> $stable({chan_val, chan_pd, write_through}))
    else $error("outputs moved");
  a_chain_idle: assert property (pins.frame_n [*6] |-> !chain_out)
    else $error("chain busy idle");
  a_reset_zero: assert property ($rose(nrst) |-> chan_val == '0 && chan_pd == '0 && !write_through)
    else $error("not zero at reset");
endmodule  // odsfi_props

bind odsfi_top odsfi_props i_props (.*);

//--- tb/tb.sv
// Self-checking bench for the serial frame input
module tb;
  timeunit 1ns / 1ps;
  import odsfi_pkg::*;
  logic                           clk = 1'b0;
  logic                           nrst = 1'b0;
  logic                           ce = 1'b1;
  logic                           chain_out, write_through, update_pulse, abort_pulse;
  logic                           exp_wt = 1'b0;
  logic [CHAN_N-1:0]              chan_pd;
  logic [CHAN_N-1:0]              exp_pd = '0;
  logic [CHAN_N-1:0][VAL_W-1:0]   chan_val, exp_reg = '0, exp_out = '0;
  logic [VAL_W*CHAN_N+CHAN_N+1:0] q[$];
  int                             cyc, failures, tests_run, chain_hi;
  odsfi_pins_t                    pins;

  odsfi_top i_dut (.*);
  odsfi_host i_host (.*);

  always #12.5 clk = ~clk;

  task automatic fail(input string m);
    failures++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Short frames leave every expectation as it was
  task automatic xfer(input logic [31:0] b, input int n);
    if (n >= FULL_EDGES) begin
      case (b[15:12])
        CMD_MODE_WRM: exp_wt = 1'b0;
        CMD_MODE_WTM: exp_wt = 1'b1;
        CMD_UPDATE:
          for (int i = 0; i < CHAN_N; i++)
            if (b[i])
              exp_out[i] = exp_reg[i];
        CMD_CHA_ALL: begin
          exp_reg[0] = b[11:0];
          exp_out = exp_reg;
        end
        CMD_ALL: begin
          exp_reg = {CHAN_N{b[11:0]}};
          exp_out = exp_reg;
        end
        CMD_PD: exp_pd = exp_pd | b[7:0];
        default: begin
          exp_reg[b[14:12]] = b[11:0];
          if (exp_wt)
            exp_out[b[14:12]] = b[11:0];
        end
      endcase
    end
    q.push_back({n < FULL_EDGES, exp_out, exp_pd, exp_wt});
    i_host.send(b, n);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      complete_run();
    end
    if (chain_out === 1'b1)
      chain_hi++;
    if (update_pulse === 1'b1 || abort_pulse === 1'b1) begin
      tests_run++;
      if (q.size() == 0 || {abort_pulse, chan_val, chan_pd, write_through} !== q.pop_front())
        fail("result mismatch");
    end
  end

  initial begin
    void'($urandom(83));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    xfer($urandom, 14);
    xfer($urandom, 0);
    xfer({CMD_MODE_WTM, 12'h000}, 16);
    for (int c = 0; c < CHAN_N; c++)
      xfer({c[3:0], 12'($urandom)}, 16);
    xfer({CMD_MODE_WRM, 12'h000}, 16);
    xfer({4'h3, 12'($urandom)}, 16);
    xfer({CMD_UPDATE, 4'h0, 8'($urandom)}, 16);
    xfer({CMD_CHA_ALL, 12'($urandom)}, 16);
    tests_run++;
    if (chain_hi != 0) fail("chain active in short frame");
    xfer({4'($urandom), CMD_ALL, 12'($urandom)}, 20);
    xfer({CMD_PD, 4'h0, 8'($urandom)}, 16);
    repeat (10) @(posedge clk);
    tests_run++;
    if (chain_hi == 0) fail("chain silent in long frame");
    if (q.size() != 0)
      fail("result missing");
    complete_run();
  end
endmodule  // tb
